// ---- hdl/pds_addr_gen.sv ----
`timescale 1ns/1ps
module pds_addr_gen
(
   // Clock and reset
   input  wire logic                           core_clk,
   input  wire logic                           sys_rst,
   // Request from the core
   input  wire logic                           req_valid,
   input  wire logic                           req_write,
   input  wire logic [pds_pkg::PTR_W-1:0]      req_ptr,
   input  wire logic [pds_pkg::RD_PAGE_W-1:0]  read_page_select,
   input  wire logic [pds_pkg::PAGE_LOW_W-1:0] write_page_select,
   input  wire logic                           rpt_active,
   // Answer to the core
   output      logic                           req_ready,
   output      logic                           ack,
   output      logic                           ack_write,
   output      logic [pds_pkg::ADDR_W-1:0]     effective_pointer,
   output      pds_pkg::pds_target_t           access_target,
   output      logic                           addr_err_trap
);

   pds_pkg::pds_regs_t  st_r;
   pds_pkg::pds_regs_t  st_nxt;
   logic [1:0]          cyc;

   pds_addr_if  fif ();

   assign fif.ptr      = req_ptr;
   assign fif.is_write = req_write;
   assign fif.rd_page  = read_page_select;
   assign fif.wr_page  = write_page_select;

   pds_addr_form u_form
   (
      .fif (fif.form)
   );

   always_comb
   begin
      cyc            = pds_pkg::CYC_SINGLE;
      st_nxt         = st_r;
      st_nxt.ack     = 1'b0;
      st_nxt.trap    = 1'b0;
      // Repeat run ends: the next run starts slow again
      if (!rpt_active)
      begin
         st_nxt.rpt_cnt = pds_pkg::CNT_RST;
      end
      case (st_r.state)
         pds_pkg::ST_IDLE:
         begin
            if (req_valid)
            begin
               st_nxt.eff       = fif.addr;
               st_nxt.target    = fif.target;
               st_nxt.trap      = fif.trap;
               st_nxt.ack_write = req_write;
               // Writes, base accesses and traps all finish in one cycle
               if (!fif.trap && !req_write && fif.target != pds_pkg::TGT_BASE)
               begin
                  if (rpt_active && st_r.rpt_cnt < pds_pkg::RPT_SLOW_CNT)
                  begin
                     cyc            = pds_pkg::CYC_RPT_FIRST;
                     st_nxt.rpt_cnt = st_r.rpt_cnt + pds_pkg::CNT_STEP;
                  end
                  else if (rpt_active)
                  begin
                     cyc = pds_pkg::CYC_SINGLE;
                  end
                  else
                  begin
                     cyc = pds_pkg::CYC_PAGED_RD;
                  end
               end
               if (cyc == pds_pkg::CYC_SINGLE)
               begin
                  st_nxt.ack = 1'b1;
               end
               else
               begin
                  st_nxt.state = pds_pkg::ST_BUSY;
                  st_nxt.cnt   = cyc - pds_pkg::CNT_STEP;
               end
            end
         end
         pds_pkg::ST_BUSY:
         begin
            if (st_r.cnt == pds_pkg::CNT_LAST)
            begin
               st_nxt.ack   = 1'b1;
               st_nxt.state = pds_pkg::ST_IDLE;
               st_nxt.cnt   = pds_pkg::CNT_RST;
            end
            else
            begin
               st_nxt.cnt = st_r.cnt - pds_pkg::CNT_STEP;
            end
         end
         default:
         begin
            st_nxt.state = pds_pkg::ST_IDLE;
            st_nxt.cnt   = pds_pkg::CNT_RST;
         end
      endcase
      // Ready is registered so the core sees the stall from the flop
      st_nxt.ready = (st_nxt.state == pds_pkg::ST_IDLE);
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         st_r.state     <= pds_pkg::ST_IDLE;
         st_r.cnt       <= pds_pkg::CNT_RST;
         st_r.rpt_cnt   <= pds_pkg::CNT_RST;
         st_r.ready     <= 1'b1;
         st_r.ack       <= 1'b0;
         st_r.ack_write <= 1'b0;
         st_r.trap      <= 1'b0;
         st_r.target    <= pds_pkg::TGT_BASE;
         st_r.eff       <= pds_pkg::EFF_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign req_ready         = st_r.ready;
   assign ack               = st_r.ack;
   assign ack_write         = st_r.ack_write;
   assign effective_pointer = st_r.eff;
   assign access_target     = st_r.target;
   assign addr_err_trap     = st_r.trap;

   // Checks
   logic                           acc;
   logic                           win;
   logic [pds_pkg::OFS_W-1:0]      ptr_ofs;
   logic [pds_pkg::PAGE_LOW_W-1:0] rd_low;
   logic                           paged_rd;

   assign acc      = req_valid && req_ready;
   assign win      = req_ptr[pds_pkg::WINDOW_BIT];
   assign ptr_ofs  = req_ptr[pds_pkg::OFS_W-1:0];
   assign rd_low   = read_page_select[pds_pkg::PAGE_LOW_W-1:0];
   assign paged_rd = acc && win && !req_write && read_page_select != pds_pkg::RD_PAGE_ZERO;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   property p_trap_page0;
      acc && win && ((req_write && write_page_select == pds_pkg::WR_PAGE_ZERO) ||
                     (!req_write && read_page_select == pds_pkg::RD_PAGE_ZERO))
      |=> ack && addr_err_trap && req_ready;
   endproperty
   a_trap_page0: assert property (p_trap_page0)
      else $error("page zero window access did not trap");

   property p_base_direct;
      acc && !win |=> ack && !addr_err_trap && access_target == pds_pkg::TGT_BASE
                      && effective_pointer == {pds_pkg::BASE_HI, $past(req_ptr)};
   endproperty
   a_base_direct: assert property (p_base_direct)
      else $error("base access address wrong");

   property p_read_concat;
      paged_rd && !read_page_select[pds_pkg::PROG_VIEW_BIT] && !rpt_active
      |=> !ack ##1 ack && access_target == pds_pkg::TGT_PAGED
          && effective_pointer == {$past(rd_low, 2), $past(ptr_ofs, 2)};
   endproperty
   a_read_concat: assert property (p_read_concat)
      else $error("paged read address or timing wrong");

   property p_write_concat;
      acc && win && req_write && write_page_select != pds_pkg::WR_PAGE_ZERO
      |=> ack && ack_write && access_target == pds_pkg::TGT_PAGED
          && effective_pointer == {$past(write_page_select), $past(ptr_ofs)};
   endproperty
   a_write_concat: assert property (p_write_concat)
      else $error("paged write address wrong");

   property p_read_stall;
      paged_rd && !rpt_active |=> !req_ready ##1 req_ready;
   endproperty
   a_read_stall: assert property (p_read_stall)
      else $error("paged read did not take two cycles");

   property p_rpt_first;
      paged_rd && rpt_active && st_r.rpt_cnt < pds_pkg::RPT_SLOW_CNT
      |=> !ack [*2] ##1 ack;
   endproperty
   a_rpt_first: assert property (p_rpt_first)
      else $error("early repeat read not three cycles");

   property p_rpt_later;
      paged_rd && rpt_active && st_r.rpt_cnt == pds_pkg::RPT_SLOW_CNT |=> ack && req_ready;
   endproperty
   a_rpt_later: assert property (p_rpt_later)
      else $error("later repeat read not one cycle");

   property p_prog_view;
      paged_rd && read_page_select[pds_pkg::PROG_VIEW_BIT]
      |-> ##[1:3] ack && access_target == pds_pkg::TGT_PROG_VIEW;
   endproperty
   a_prog_view: assert property (p_prog_view)
      else $error("program view read misrouted");

   property p_read_ignores_wr;
      paged_rd |=> (effective_pointer == {$past(rd_low), $past(ptr_ofs)} && !ack_write
                    && access_target != pds_pkg::TGT_BASE) ##[0:2] ack;
   endproperty
   a_read_ignores_wr: assert property (p_read_ignores_wr)
      else $error("read took the write path");

   property p_hold_addr;
      !acc && !ack |=> $stable(effective_pointer);
   endproperty
   a_hold_addr: assert property (p_hold_addr)
      else $error("address moved without a request");

   c_trap:      cover property (acc && win && read_page_select == pds_pkg::RD_PAGE_ZERO);
   c_rpt_run:   cover property (paged_rd && rpt_active && st_r.rpt_cnt == pds_pkg::RPT_SLOW_CNT);
   c_write:     cover property (acc && win && req_write ##1 ack);
   c_prog_view: cover property (ack && access_target == pds_pkg::TGT_PROG_VIEW);

endmodule

// ---- hdl/pds_pkg.sv ----
package pds_pkg;

   // Page geometry: one page is the 32 Kbyte window in the upper data half
   localparam int PAGE_BYTES    = 32768;
   localparam int OFS_W         = $clog2(PAGE_BYTES);
   localparam int PTR_W         = 16;
   localparam int ADDR_W        = 24;
   localparam int RD_PAGE_W     = 10;
   localparam int PAGE_LOW_W    = 9;
   localparam int BASE_HI_W     = ADDR_W - PTR_W;

   // Field positions
   localparam int WINDOW_BIT    = 15;
   localparam int PROG_VIEW_BIT = 9;

   // Fixed values
   localparam logic [BASE_HI_W-1:0]  BASE_HI       = 8'h00;
   localparam logic [RD_PAGE_W-1:0]  RD_PAGE_ZERO  = 10'h000;
   localparam logic [PAGE_LOW_W-1:0] WR_PAGE_ZERO  = 9'h000;
   localparam logic [ADDR_W-1:0]     EFF_RST       = 24'h000000;

   // Access lengths in instruction cycles
   localparam logic [1:0] CYC_SINGLE    = 2'h1;
   localparam logic [1:0] CYC_PAGED_RD  = 2'h2;
   localparam logic [1:0] CYC_RPT_FIRST = 2'h3;
   localparam logic [1:0] RPT_SLOW_CNT  = 2'h2;
   localparam logic [1:0] CNT_STEP      = 2'h1;
   localparam logic [1:0] CNT_LAST      = 2'h1;
   localparam logic [1:0] CNT_RST       = 2'h0;

   typedef enum logic [1:0]
   {
      TGT_BASE      = 2'h0,
      TGT_PAGED     = 2'h1,
      TGT_PROG_VIEW = 2'h3
   } pds_target_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h0,
      ST_BUSY = 2'h1
   } pds_state_t;

   typedef struct packed
   {
      pds_state_t          state;
      logic [1:0]          cnt;
      logic [1:0]          rpt_cnt;
      logic                ready;
      logic                ack;
      logic                ack_write;
      logic                trap;
      pds_target_t         target;
      logic [ADDR_W-1:0]   eff;
   } pds_regs_t;

endpackage

// ---- hdl/pds_addr_if.sv ----
`timescale 1ns/1ps
interface pds_addr_if;
   logic [pds_pkg::PTR_W-1:0]      ptr;
   logic                           is_write;
   logic [pds_pkg::RD_PAGE_W-1:0]  rd_page;
   logic [pds_pkg::PAGE_LOW_W-1:0] wr_page;
   logic [pds_pkg::ADDR_W-1:0]     addr;
   pds_pkg::pds_target_t           target;
   logic                           trap;

   modport req  (output ptr, output is_write, output rd_page, output wr_page,
                 input addr, input target, input trap);
   modport form (input ptr, input is_write, input rd_page, input wr_page,
                 output addr, output target, output trap);
endinterface

// ---- hdl/pds_addr_form.sv ----
`timescale 1ns/1ps
module pds_addr_form
(
   // Pointer and pages in, address out
   pds_addr_if.form  fif
);

   always_comb
   begin
      fif.addr   = {pds_pkg::BASE_HI, fif.ptr};
      fif.target = pds_pkg::TGT_BASE;
      fif.trap   = 1'b0;
      // No carry leaves the offset: a wrap stays inside the page
      if (fif.ptr[pds_pkg::WINDOW_BIT])
      begin
         if (fif.is_write)
         begin
            fif.addr   = {fif.wr_page, fif.ptr[pds_pkg::OFS_W-1:0]};
            fif.target = pds_pkg::TGT_PAGED;
            fif.trap   = (fif.wr_page == pds_pkg::WR_PAGE_ZERO);
         end
         else
         begin
            fif.addr   = {fif.rd_page[pds_pkg::PAGE_LOW_W-1:0],
                          fif.ptr[pds_pkg::OFS_W-1:0]};
            fif.target = fif.rd_page[pds_pkg::PROG_VIEW_BIT] ?
                         pds_pkg::TGT_PROG_VIEW : pds_pkg::TGT_PAGED;
            fif.trap   = (fif.rd_page == pds_pkg::RD_PAGE_ZERO);
         end
      end
   end

endmodule

// ---- verif/pds_core_model.sv ----
`timescale 1ns/1ps
module pds_core_model
(
   // Clock and reset
   input  wire logic                           core_clk,
   input  wire logic                           sys_rst,
   // Orders from the bench
   input  wire logic                           cmd_go,
   input  wire logic                           cmd_write,
   input  wire logic [pds_pkg::PTR_W-1:0]      cmd_ptr,
   input  wire logic [pds_pkg::RD_PAGE_W-1:0]  cmd_rd_page,
   input  wire logic [pds_pkg::PAGE_LOW_W-1:0] cmd_wr_page,
   // Core side of the generator
   output      logic                           req_valid,
   output      logic                           req_write,
   output      logic [pds_pkg::PTR_W-1:0]      req_ptr,
   output      logic [pds_pkg::RD_PAGE_W-1:0]  read_page_select,
   output      logic [pds_pkg::PAGE_LOW_W-1:0] write_page_select,
   input  wire logic                           req_ready
);
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         req_valid         <= 1'b0;
         req_write         <= 1'b0;
         req_ptr           <= 16'h0000;
         read_page_select  <= 10'h000;
         write_page_select <= 9'h000;
      end
      else if (cmd_go && !req_valid)
      begin
         // Page loaded with the offset; window bit comes with the pointer
         req_valid         <= 1'b1;
         req_write         <= cmd_write;
         req_ptr           <= cmd_ptr;
         read_page_select  <= cmd_rd_page;
         write_page_select <= cmd_wr_page;
      end
      else if (req_valid && req_ready)
      begin
         // Stale write flag and pointer inverted so the generator cannot lean on them
         req_valid <= 1'b0;
         req_write <= ~req_write;
         req_ptr   <= ~req_ptr;
      end
   end
endmodule

// ---- verif/pds_addr_gen_bench.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) samples_checked++; if ((g) !== (e)) begin $display("BAD %s exp %0h got %0h", nm, e, g); mismatches++; end
module pds_addr_gen_bench;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        cmd_go = 1'b0;
   logic        cmd_write = 1'b0;
   logic [15:0] cmd_ptr = 16'h0000;
   logic [9:0]  cmd_rd_page = 10'h000;
   logic [8:0]  cmd_wr_page = 9'h000;
   logic        rpt_active = 1'b0;
   logic        req_valid, req_write, req_ready, ack, ack_write, addr_err_trap;
   logic [15:0] req_ptr;
   logic [9:0]  read_page_select;
   logic [8:0]  write_page_select;
   logic [23:0] effective_pointer;
   pds_pkg::pds_target_t access_target;
   int          mismatches = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          rcnt = 0;
   logic [31:0] xs_state = 32'h00000054;

   pds_core_model pds_core_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .cmd_go(cmd_go),
      .cmd_write(cmd_write), .cmd_ptr(cmd_ptr), .cmd_rd_page(cmd_rd_page),
      .cmd_wr_page(cmd_wr_page), .req_valid(req_valid), .req_write(req_write),
      .req_ptr(req_ptr), .read_page_select(read_page_select),
      .write_page_select(write_page_select), .req_ready(req_ready));
   pds_addr_gen pds_addr_gen_i (.core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid),
      .req_write(req_write), .req_ptr(req_ptr), .read_page_select(read_page_select),
      .write_page_select(write_page_select), .rpt_active(rpt_active), .req_ready(req_ready),
      .ack(ack), .ack_write(ack_write), .effective_pointer(effective_pointer),
      .access_target(access_target), .addr_err_trap(addr_err_trap));

   initial
   begin
      forever #5 core_clk = ~core_clk;
   end

   // Hang guard, generous over the nine hundred or so cycles the run needs
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         wrap_up();
      end
   end

   function automatic logic [31:0] xorshift();
      logic [31:0] x;
      x = xs_state;
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      xs_state = x;
      return x;
   endfunction

   function automatic logic [23:0] exp_addr(logic wr, logic [15:0] p, logic [9:0] rp,
                                             logic [8:0] wp);
      if (!p[15])
         return {8'h00, p};
      return wr ? {wp, p[14:0]} : {rp[8:0], p[14:0]};
   endfunction

   task automatic wrap_up();
      if (mismatches == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic access(input logic wr, input logic [15:0] p, input logic [9:0] rp,
                         input logic [8:0] wp, input logic rpt);
      int   lat;
      int   elat;
      logic etrap;
      pds_pkg::pds_target_t etgt;
      etrap = p[15] && (wr ? (wp == 9'h000) : (rp == 10'h000));
      etgt  = !p[15] ? pds_pkg::TGT_BASE :
              (!wr && rp[9]) ? pds_pkg::TGT_PROG_VIEW : pds_pkg::TGT_PAGED;
      if (!rpt)
         rcnt = 0;
      elat = 1;
      if (!wr && p[15] && !etrap)
      begin
         elat = !rpt ? 2 : (rcnt < 2) ? 3 : 1;
         if (rpt && rcnt < 2)
            rcnt++;
      end
      cmd_go      <= 1'b1;
      cmd_write   <= wr;
      cmd_ptr     <= p;
      cmd_rd_page <= rp;
      cmd_wr_page <= wp;
      rpt_active  <= rpt;
      @(posedge core_clk);
      cmd_go <= 1'b0;
      do @(posedge core_clk); while (!(req_valid && req_ready));
      lat = 1;
      #1;
      while (ack !== 1'b1 && lat < 8)
      begin
         `CHK("ready_busy", 1'b0, req_ready)
         @(posedge core_clk);
         #1;
         lat++;
      end
      `CHK("latency", elat, lat)
      `CHK("trap", etrap, addr_err_trap)
      `CHK("ack_write", wr, ack_write)
      `CHK("ready_ack", 1'b1, req_ready)
      if (!etrap)
      begin
         `CHK("address", exp_addr(wr, p, rp, wp), effective_pointer)
         `CHK("target", etgt, access_target)
      end
      @(posedge core_clk);
      #1;
      `CHK("ack_pulse", 1'b0, ack)
      `CHK("trap_pulse", 1'b0, addr_err_trap)
      // Realign so the next call drives on a rising edge
      @(posedge core_clk);
   endtask

   initial
   begin
      logic [31:0] r;
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      access(1'b0, 16'h8800, 10'h002, 9'h1FF, 1'b0);
      access(1'b1, 16'h8800, 10'h1FF, 9'h002, 1'b0);
      access(1'b0, 16'h7FFF, 10'h3FF, 9'h1FF, 1'b0);
      access(1'b1, 16'h0800, 10'h000, 9'h000, 1'b0);
      access(1'b0, 16'h8000, 10'h000, 9'h0AA, 1'b0);
      access(1'b1, 16'hFFFE, 10'h155, 9'h000, 1'b0);
      access(1'b0, 16'h9234, 10'h205, 9'h000, 1'b0);
      access(1'b0, 16'hFFFF, 10'h1FF, 9'h001, 1'b0);
      access(1'b0, 16'h8000, 10'h1FF, 9'h001, 1'b0);
      for (int i = 0; i < 4; i++)
         access(1'b0, 16'h8000 + 16'(2 * i), 10'h003, 9'h004, 1'b1);
      access(1'b0, 16'h8010, 10'h000, 9'h004, 1'b1);
      access(1'b0, 16'hC000, 10'h204, 9'h004, 1'b1);
      for (int i = 0; i < 200; i++)
      begin
         r = xorshift();
         access(r[0], r[31:16], r[1] ? r[14:5] : {1'b0, r[13:5]}, r[12:4], r[2] & r[3]);
      end
      wrap_up();
   end
endmodule
